// ### design/vps_pkg.sv
// Constants shared by the emulated PHY status and identifier register block.
package vps_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam logic [11:0] VPS_STATUS_OFFSET   = 12'h1C4;
    localparam logic [11:0] VPS_OUI_UP_OFFSET   = 12'h1C8;
    localparam logic [4:0]  VPS_STATUS_INDEX    = 5'h01;
    localparam logic [4:0]  VPS_OUI_UP_INDEX    = 5'h02;

    // ****************************************
    // Status field positions
    // ****************************************
    localparam int VPS_BIT_T4        = 15;
    localparam int VPS_BIT_X_FD      = 14;
    localparam int VPS_BIT_X_HD      = 13;
    localparam int VPS_BIT_T_FD      = 12;
    localparam int VPS_BIT_T_HD      = 11;
    localparam int VPS_BIT_T2_FD     = 10;
    localparam int VPS_BIT_T2_HD     = 9;
    localparam int VPS_BIT_EXT_STAT  = 8;
    localparam int VPS_BIT_RSVD7     = 7;
    localparam int VPS_BIT_PRE_SUPP  = 6;
    localparam int VPS_BIT_AN_DONE   = 5;
    localparam int VPS_BIT_RFAULT    = 4;
    localparam int VPS_BIT_AN_ABLE   = 3;
    localparam int VPS_BIT_LINK      = 2;
    localparam int VPS_BIT_JABBER    = 1;
    localparam int VPS_BIT_EXT_CAP   = 0;

    // Status value apart from the negotiation complete bit.
    localparam logic [15:0] VPS_STATUS_FIXED = 16'h780D;

    // ****************************************
    // Reset values and timing
    // ****************************************
    // Identifier default is arbitrary and carries no maker meaning.
    localparam logic [15:0] VPS_OUI_UP_RESET  = 16'h5A3C;
    localparam int          VPS_CLOCK_NS      = 10;
    localparam int          VPS_AN_TIME_NS    = 1000;
    localparam int          VPS_AN_CYCLES     = (VPS_AN_TIME_NS + VPS_CLOCK_NS - 1) / VPS_CLOCK_NS;

    typedef enum logic [0:0] {
        VPS_AN_RUN  = 1'b0,
        VPS_AN_DONE = 1'b1
    } vps_an_state_type;

endpackage : vps_pkg

// ### design/vps_regs.sv
// Emulated PHY basic status and upper identifier registers with two access ports.
`timescale 1ns/1ps
// ****************************************
// Overview of operation
// ****************************************
// Overview of operation
// (RULE1) Each register is a 32-bit word, upper half padding; management sees 16 bits.
// (RULE2) Status lives at offset 1C4h and management index 1.
// (RULE3) Status bit 15, 100BASE-T4 ability, always reads zero.
// (RULE4) Status bits 14 to 11 read one for the four supported modes.
// (RULE5) Status bits 10 and 9, 100BASE-T2 abilities, read zero.
// (RULE6) Status bit 8 reads zero: no extended status, no gigabit.
// (RULE7) Bit 6 reads zero; the master must always send a full preamble.
// (RULE8) Negotiation complete bit clears on reset and sets once emulation finishes.
// (RULE9) No remote fault, link up and no jabber are constant.
// (RULE10) Status bit 3 reads one: negotiation ability present.
// (RULE11) Status bit 0 reads one: extended registers 0 to 6 exist.
// (RULE12) Status is read only; writes change nothing.
// (RULE13) Upper identifier lives at offset 1C8h and management index 2.
// (RULE14) Upper identifier bits 15 to 0 are a writable field.
// (RULE15) Any identifier value, including all zero, is accepted.
// (RULE16) Soft reset returns both registers to their defaults.
// (RULE17) Negotiation restart recomputes the emulated negotiation result.
// (RULE18) Reserved bit 7 and upper halves read zero and ignore writes.
// (RULE19) A written identifier reads back unchanged until reset or rewrite.
module vps_regs
    import vps_pkg::*;
#(
    parameter int          AN_DELAY    = VPS_AN_CYCLES,
    parameter logic [15:0] OUI_DEFAULT = VPS_OUI_UP_RESET
) (
    input  wire logic        i_clock,         // System clock.
    input  wire logic        i_srst,          // Synchronous reset, active high.
    input  wire logic        i_soft_reset,    // Control soft reset pulse.
    input  wire logic        i_an_restart,    // Control negotiation restart pulse.
    input  wire logic        i_reg_rd,        // Internal map read strobe.
    input  wire logic        i_reg_wr,        // Internal map write strobe.
    input  wire logic [11:0] i_reg_addr,      // Internal map byte offset.
    input  wire logic [31:0] i_reg_wdata,     // Internal map write data.
    output logic      [31:0] o_reg_rdata,     // Internal map read data.
    output logic             o_reg_rvalid,    // Internal read data valid.
    input  wire logic        i_mgmt_rd,       // Management read strobe.
    input  wire logic        i_mgmt_wr,       // Management write strobe.
    input  wire logic [4:0]  i_mgmt_index,    // Management register index.
    input  wire logic [15:0] i_mgmt_wdata,    // Management write data.
    output logic      [15:0] o_mgmt_rdata,    // Management read data.
    output logic             o_mgmt_rvalid,   // Management read data valid.
    output logic             o_an_complete    // Emulated negotiation done.
);

    localparam int CW = 16;
    localparam logic [CW-1:0] AN_LAST = CW'(AN_DELAY - 1);

    vps_an_state_type  an_state_q;
    logic [CW-1:0]     an_cnt_q;
    logic [15:0]       oui_q;
    logic [15:0]       status_w;
    logic              int_oui_wr;
    logic              mgmt_oui_wr;

    // ****************************************
    // Register read decode
    // ****************************************
    function automatic logic [15:0] read_word(input logic sel_status, input logic sel_oui,
                                              input logic [15:0] stat,
                                              input logic [15:0] oui);
        read_word = 16'h0000;
        if (sel_status) begin
            read_word = stat;
        end else if (sel_oui) begin
            read_word = oui;
        end
    endfunction : read_word

    // Every status field is a constant apart from negotiation complete.
    // Bit 6 stays low, so management frames must always carry a full preamble.
    always_comb begin
        status_w                   = 16'h0000;
        status_w[VPS_BIT_T4]       = 1'b0;                            // RULE3
        status_w[VPS_BIT_X_FD]     = 1'b1;                            // RULE4
        status_w[VPS_BIT_X_HD]     = 1'b1;                            // RULE4
        status_w[VPS_BIT_T_FD]     = 1'b1;                            // RULE4
        status_w[VPS_BIT_T_HD]     = 1'b1;                            // RULE4
        status_w[VPS_BIT_T2_FD]    = 1'b0;                            // RULE5
        status_w[VPS_BIT_T2_HD]    = 1'b0;                            // RULE5
        status_w[VPS_BIT_EXT_STAT] = 1'b0;                            // RULE6
        status_w[VPS_BIT_RSVD7]    = 1'b0;                            // RULE18
        status_w[VPS_BIT_PRE_SUPP] = 1'b0;                            // RULE7
        status_w[VPS_BIT_AN_DONE]  = (an_state_q == VPS_AN_DONE);     // RULE8
        status_w[VPS_BIT_RFAULT]   = 1'b0;                            // RULE9
        status_w[VPS_BIT_AN_ABLE]  = 1'b1;                            // RULE10
        status_w[VPS_BIT_LINK]     = 1'b1;                            // RULE9
        status_w[VPS_BIT_JABBER]   = 1'b0;                            // RULE9
        status_w[VPS_BIT_EXT_CAP]  = 1'b1;                            // RULE11
    end

    assign int_oui_wr    = i_reg_wr && (i_reg_addr == VPS_OUI_UP_OFFSET);    // RULE12
    assign mgmt_oui_wr   = i_mgmt_wr && (i_mgmt_index == VPS_OUI_UP_INDEX);
    assign o_an_complete = (an_state_q == VPS_AN_DONE);

    // ****************************************
    // Emulated negotiation
    // ****************************************
    // The counter runs for AN_DELAY cycles after the last reset source, then complete latches.
    // Restart leaves the identifier alone; only the negotiation result is worked out again.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_soft_reset || i_an_restart) begin              // RULE16 RULE17
            an_state_q <= VPS_AN_RUN;                                 // RULE8
            an_cnt_q   <= '0;
        end else begin
            case (an_state_q)
                VPS_AN_RUN: begin
                    if (an_cnt_q == AN_LAST) begin
                        an_state_q <= VPS_AN_DONE;                    // RULE8
                    end else begin
                        an_cnt_q <= an_cnt_q + CW'(1);
                    end
                end
                VPS_AN_DONE: begin
                    an_state_q <= VPS_AN_DONE;
                end
                default: begin
                    an_state_q <= VPS_AN_RUN;
                end
            endcase
        end
    end

    // ****************************************
    // Upper identifier storage
    // ****************************************
    // The internal port wins when both ports write in the same cycle.
    // Soft reset outranks both ports, so a reset and a write together leave the default.
    always_ff @(posedge i_clock) begin
        if (i_srst || i_soft_reset) begin
            oui_q <= OUI_DEFAULT;                                     // RULE16
        end else if (int_oui_wr) begin
            oui_q <= i_reg_wdata[15:0];                               // RULE14 RULE15 RULE18
        end else if (mgmt_oui_wr) begin
            oui_q <= i_mgmt_wdata;                                    // RULE14 RULE19
        end
    end

    // ****************************************
    // Read ports
    // ****************************************
    // Read data is registered and holds between reads; valid is the read strobe delayed by one cycle.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_reg_rdata  <= 32'h0000_0000;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= {16'h0000,                             // RULE1 RULE18
                                read_word(i_reg_addr == VPS_STATUS_OFFSET,   // RULE2
                                          i_reg_addr == VPS_OUI_UP_OFFSET,   // RULE13
                                          status_w, oui_q)};
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            o_mgmt_rdata  <= 16'h0000;
            o_mgmt_rvalid <= 1'b0;
        end else begin
            o_mgmt_rvalid <= i_mgmt_rd;
            if (i_mgmt_rd) begin
                o_mgmt_rdata <= read_word(i_mgmt_index == VPS_STATUS_INDEX,  // RULE1 RULE2
                                          i_mgmt_index == VPS_OUI_UP_INDEX,  // RULE13
                                          status_w, oui_q);
            end
        end
    end

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    // Status checks compare against the package constant, not the assembled word.
    AST_UPPER_ZERO: assert property ( // RULE1
        o_reg_rvalid |-> o_reg_rdata[31:16] == 16'h0000)
        else $error("Upper half of internal read data is not zero.");

    // Read data is taken from the state before the edge, so bit 5 is compared one cycle back.
    AST_STATUS_INT: assert property ( // RULE2
        i_reg_rd && i_reg_addr == VPS_STATUS_OFFSET |=>
        o_reg_rvalid && o_reg_rdata[15:0] ==
        (VPS_STATUS_FIXED | {10'h000, $past(o_an_complete), 5'h00}))
        else $error("Internal status read returned a wrong value.");

    AST_STATUS_MGMT: assert property ( // RULE2
        i_mgmt_rd && i_mgmt_index == VPS_STATUS_INDEX |=>
        o_mgmt_rvalid && o_mgmt_rdata ==
        (VPS_STATUS_FIXED | {10'h000, $past(o_an_complete), 5'h00}))
        else $error("Management status read returned a wrong value.");

    AST_RESERVED_BIT: assert property ( // RULE18
        i_reg_rd && i_reg_addr == VPS_STATUS_OFFSET |=> !o_reg_rdata[VPS_BIT_RSVD7])
        else $error("Reserved status bit 7 is not zero.");

    // Any offset outside the two registers reads as zero.
    AST_UNMAPPED_ZERO: assert property ( // RULE18
        i_reg_rd && i_reg_addr != VPS_STATUS_OFFSET && i_reg_addr != VPS_OUI_UP_OFFSET
        |=> o_reg_rdata == 32'h0000_0000)
        else $error("Unmapped internal read did not return zero.");

    // A read strobe during reset is dropped, so valid follows only strobes taken outside it.
    AST_INT_RVALID: assert property ( // RULE2
        o_reg_rvalid == ($past(i_reg_rd) && !$past(i_srst)))
        else $error("Internal read valid does not follow the read strobe.");

    AST_MGMT_RVALID: assert property ( // RULE13
        o_mgmt_rvalid == ($past(i_mgmt_rd) && !$past(i_srst)))
        else $error("Management read valid does not follow the read strobe.");

    AST_STATUS_ZERO_BITS: assert property ( // RULE3
        i_mgmt_rd && i_mgmt_index == VPS_STATUS_INDEX |=>
        o_mgmt_rdata[15:6] == 10'h1E0)
        else $error("Status ability bits 15 to 6 are wrong.");

    AST_STATUS_LOW_BITS: assert property ( // RULE9
        i_mgmt_rd && i_mgmt_index == VPS_STATUS_INDEX |=>
        o_mgmt_rdata[4:0] == 5'h0D && o_mgmt_rdata[5] == $past(o_an_complete))
        else $error("Status bits 5 to 0 are wrong.");

    // ****************************************
    // Negotiation assertions
    // ****************************************
    // Every reset source clears the counter, so complete stays low while it runs.
    AST_AN_CLEARS: assert property ( // RULE8
        i_soft_reset || i_an_restart |=> !o_an_complete [*2])
        else $error("Negotiation complete did not clear.");

    AST_AN_SETS: assert property ( // RULE17
        an_state_q == VPS_AN_RUN && an_cnt_q == AN_LAST && !i_soft_reset && !i_an_restart
        |=> o_an_complete)
        else $error("Negotiation complete did not set on time.");

    AST_AN_COUNT: assert property ( // RULE8
        an_state_q == VPS_AN_RUN |-> an_cnt_q <= AN_LAST)
        else $error("Negotiation counter ran past its end.");

    // ****************************************
    // Identifier assertions
    // ****************************************

    AST_OUI_WRITE: assert property ( // RULE19
        int_oui_wr && !i_soft_reset |=> oui_q == $past(i_reg_wdata[15:0]))
        else $error("Identifier write was not stored.");

    AST_OUI_MGMT_READ: assert property ( // RULE13
        i_mgmt_rd && i_mgmt_index == VPS_OUI_UP_INDEX |=>
        o_mgmt_rvalid && o_mgmt_rdata == $past(oui_q))
        else $error("Management identifier read returned a wrong value.");

    AST_OUI_INT_READ: assert property ( // RULE13
        i_reg_rd && i_reg_addr == VPS_OUI_UP_OFFSET |=>
        o_reg_rvalid && o_reg_rdata == {16'h0000, $past(oui_q)})
        else $error("Internal identifier read returned a wrong value.");

    // A management write only lands when the internal port is not writing in the same cycle.
    AST_OUI_MGMT_WRITE: assert property ( // RULE19
        mgmt_oui_wr && !int_oui_wr && !i_soft_reset |=> oui_q == $past(i_mgmt_wdata))
        else $error("Management identifier write was not stored.");

    // Any change without a write or reset would break the read-back promise.
    AST_OUI_HOLD: assert property ( // RULE19
        !int_oui_wr && !mgmt_oui_wr && !i_soft_reset |=> $stable(oui_q))
        else $error("Identifier changed without a write or reset.");

    // Status has no storage, so a write to it may only leave the identifier untouched.
    AST_STATUS_WRITE_IGNORED: assert property ( // RULE12
        i_reg_wr && i_reg_addr == VPS_STATUS_OFFSET && !i_soft_reset && !mgmt_oui_wr
        |=> $stable(oui_q))
        else $error("Write to status changed stored state.");

    // Soft reset restores both registers in one cycle.
    AST_SOFT_RESET: assert property ( // RULE16
        i_soft_reset |=> oui_q == OUI_DEFAULT && !o_an_complete)
        else $error("Soft reset did not restore defaults.");

    AST_AN_RESTART: assert property ( // RULE17
        i_an_restart |=> an_state_q == VPS_AN_RUN && an_cnt_q == '0)
        else $error("Negotiation restart did not restart the counter.");

    AST_AN_HOLDS: assert property ( // RULE8
        o_an_complete && !i_soft_reset && !i_an_restart |=> o_an_complete)
        else $error("Negotiation complete dropped without a restart.");

    // ****************************************
    // Coverage
    // ****************************************
    // Covers mark negotiation done, a zero identifier, status reads, restart and a port clash.
    COV_AN_DONE: cover property (an_state_q == VPS_AN_RUN ##1 an_state_q == VPS_AN_DONE);
    COV_OUI_ZERO: cover property (int_oui_wr && i_reg_wdata[15:0] == 16'h0000);
    COV_MGMT_STATUS: cover property (i_mgmt_rd && i_mgmt_index == VPS_STATUS_INDEX);
    COV_RESTART: cover property (o_an_complete ##1 i_an_restart);
    COV_BOTH_WRITE: cover property (int_oui_wr && mgmt_oui_wr);

endmodule : vps_regs

// ### verification/vps_mgmt_host.sv
// Management master model that reads and writes the emulated PHY registers.
`timescale 1ns/1ps
module vps_mgmt_host (
    input  wire logic        i_clock,       // System clock.
    input  wire logic [15:0] i_mgmt_rdata,  // Read data from the device.
    input  wire logic        i_mgmt_rvalid, // Read data valid.
    output logic             o_mgmt_rd,     // Read strobe.
    output logic             o_mgmt_wr,     // Write strobe.
    output logic      [4:0]  o_mgmt_index,  // Register index.
    output logic      [15:0] o_mgmt_wdata   // Write data.
);
    // ****************************************
    // Frame issue
    // ****************************************
    initial begin
        o_mgmt_rd    = 1'b0;
        o_mgmt_wr    = 1'b0;
        o_mgmt_index = 5'h1F;
        o_mgmt_wdata = 16'hFFFF;
    end

    // Each frame is sent whole as a one-cycle strobe, so the device sees one strobe per frame.
    // Released index and data lines carry the inverse of the last value; both strobes drop to zero.
    task automatic mgmt_access(input logic is_wr, input logic [4:0] idx,
                               input logic [15:0] wdat, output logic [15:0] rdat);
        @(posedge i_clock);
        #1;
        o_mgmt_rd    = ~is_wr;
        o_mgmt_wr    = is_wr;
        o_mgmt_index = idx;
        o_mgmt_wdata = wdat;
        @(posedge i_clock);
        #1;
        rdat         = i_mgmt_rvalid ? i_mgmt_rdata : 'x;
        o_mgmt_rd    = 1'b0;
        o_mgmt_wr    = 1'b0;
        o_mgmt_index = ~idx;
        o_mgmt_wdata = ~wdat;
    endtask : mgmt_access
endmodule : vps_mgmt_host

// ### verification/testbench.sv
// Self-checking bench for the emulated PHY status and identifier registers.
`timescale 1ns/1ps
module testbench;
    import vps_pkg::*;
    logic        i_clock, i_srst, i_soft_reset, i_an_restart, i_reg_rd, i_reg_wr;
    logic [11:0] i_reg_addr;
    logic [31:0] i_reg_wdata, reg_rdata, rd32;
    logic [15:0] mgmt_wdata, mgmt_rdata, rd16;
    logic [4:0]  mgmt_index;
    logic        reg_rvalid, mgmt_rd, mgmt_wr, mgmt_rvalid, an_complete;
    logic [15:0] vals [3] = '{16'hFFFF, 16'h0000, 16'hA5C3};
    int          err_total = 0;
    int          num_checks = 0;

    vps_regs #(.AN_DELAY(4), .OUI_DEFAULT(VPS_OUI_UP_RESET)) dut (
        .i_clock(i_clock), .i_srst(i_srst), .i_soft_reset(i_soft_reset),
        .i_an_restart(i_an_restart), .i_reg_rd(i_reg_rd), .i_reg_wr(i_reg_wr),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(reg_rdata),
        .o_reg_rvalid(reg_rvalid), .i_mgmt_rd(mgmt_rd), .i_mgmt_wr(mgmt_wr),
        .i_mgmt_index(mgmt_index), .i_mgmt_wdata(mgmt_wdata), .o_mgmt_rdata(mgmt_rdata),
        .o_mgmt_rvalid(mgmt_rvalid), .o_an_complete(an_complete));

    vps_mgmt_host host (
        .i_clock(i_clock), .i_mgmt_rdata(mgmt_rdata), .i_mgmt_rvalid(mgmt_rvalid),
        .o_mgmt_rd(mgmt_rd), .o_mgmt_wr(mgmt_wr), .o_mgmt_index(mgmt_index),
        .o_mgmt_wdata(mgmt_wdata));

    // ****************************************
    // Access and checking tasks
    // ****************************************
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic complete_run;
        if (err_total == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic reg_access(input logic is_wr, input logic [11:0] addr,
                              input logic [31:0] wdat, output logic [31:0] rdat);
        @(posedge i_clock);
        #1;
        i_reg_rd    = ~is_wr;
        i_reg_wr    = is_wr;
        i_reg_addr  = addr;
        i_reg_wdata = wdat;
        @(posedge i_clock);
        #1;
        rdat        = reg_rvalid ? reg_rdata : 'x;
        i_reg_rd    = 1'b0;
        i_reg_wr    = 1'b0;
    endtask : reg_access

    task automatic pulse(input logic is_soft);
        @(posedge i_clock);
        #1;
        i_soft_reset = is_soft;
        i_an_restart = ~is_soft;
        @(posedge i_clock);
        #1;
        i_soft_reset = 1'b0;
        i_an_restart = 1'b0;
        @(posedge i_clock);
        #1;
    endtask : pulse

    task automatic wait_an;
        int n;
        n = 0;
        while (an_complete !== 1'b1 && n < 50) begin
            @(posedge i_clock);
            #1;
            n++;
        end
        if (n == 50) begin
            err_total++;
            complete_run();
        end
    endtask : wait_an

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        {i_srst, i_soft_reset, i_an_restart, i_reg_rd, i_reg_wr} = 5'b1_0000;
        i_reg_addr  = 12'h000;
        i_reg_wdata = 32'h0000_0000;
        repeat (6) @(posedge i_clock);
        #1;
        i_srst = 1'b0;
        check(an_complete, 32'h0000_0000);
        reg_access(1'b0, 12'h1C4, 32'h0, rd32);
        check(rd32, 32'h0000_780D);
        wait_an();
        reg_access(1'b0, 12'h1C4, 32'h0, rd32);
        check(rd32, 32'h0000_782D);
        host.mgmt_access(1'b0, 5'h01, 16'h0, rd16);
        check(rd16, 32'h0000_782D);
        reg_access(1'b1, 12'h1C4, 32'hFFFF_FFFF, rd32);
        host.mgmt_access(1'b1, 5'h01, 16'h0000, rd16);
        reg_access(1'b0, 12'h1C4, 32'h0, rd32);
        check(rd32, 32'h0000_782D);
        reg_access(1'b0, 12'h1C8, 32'h0, rd32);
        check(rd32, {16'h0000, VPS_OUI_UP_RESET});
        reg_access(1'b0, 12'h1CC, 32'h0, rd32);
        check(rd32, 32'h0000_0000);
        foreach (vals[i]) begin
            reg_access(1'b1, 12'h1C8, {16'hFFFF, vals[i]}, rd32);
            reg_access(1'b0, 12'h1C8, 32'h0, rd32);
            check(rd32, {16'h0000, vals[i]});
            host.mgmt_access(1'b0, 5'h02, 16'h0, rd16);
            check(rd16, vals[i]);
            host.mgmt_access(1'b1, 5'h02, ~vals[i], rd16);
            reg_access(1'b0, 12'h1C8, 32'h0, rd32);
            check(rd32, {16'h0000, ~vals[i]});
        end
        pulse(1'b1);
        check(an_complete, 32'h0000_0000);
        reg_access(1'b0, 12'h1C8, 32'h0, rd32);
        check(rd32, {16'h0000, VPS_OUI_UP_RESET});
        wait_an();
        reg_access(1'b1, 12'h1C8, 32'h0000_2222, rd32);
        pulse(1'b0);
        check(an_complete, 32'h0000_0000);
        wait_an();
        reg_access(1'b0, 12'h1C8, 32'h0, rd32);
        check(rd32, 32'h0000_2222);
        reg_access(1'b0, 12'h1C4, 32'h0, rd32);
        check(rd32, 32'h0000_782D);
        fork
            reg_access(1'b1, 12'h1C8, 32'h0000_1111, rd32);
            host.mgmt_access(1'b1, 5'h02, 16'h3333, rd16);
        join
        reg_access(1'b0, 12'h1C8, 32'h0, rd32);
        check(rd32, 32'h0000_1111);
        @(posedge i_clock);
        #1;
        i_srst = 1'b1;
        repeat (2) @(posedge i_clock);
        #1;
        i_srst = 1'b0;
        check(an_complete, 32'h0000_0000);
        reg_access(1'b0, 12'h1C8, 32'h0, rd32);
        check(rd32, {16'h0000, VPS_OUI_UP_RESET});
        wait_an();
        host.mgmt_access(1'b0, 5'h01, 16'h0, rd16);
        check(rd16, 32'h0000_782D);
        complete_run();
    end
endmodule : testbench
